// ### core/sacc_defines.vh
// register offsets, field positions, reset values and timing counts for the conversion control
`ifndef SACC_DEFINES_VH
`define SACC_DEFINES_VH
// ****************************************************************
// register map
// ****************************************************************
`define SACC_ADDR_W 2
`define SACC_OFS_CONTROL 2'h0
`define SACC_OFS_RESULT 2'h1
`define SACC_OFS_DONE 2'h2
// ****************************************************************
// control fields
// ****************************************************************
`define SACC_CLKSEL_HI 7
`define SACC_CLKSEL_LO 6
`define SACC_CHSEL_HI 5
`define SACC_CHSEL_LO 2
`define SACC_GO_BIT 1
`define SACC_ON_BIT 0
`define SACC_CLKSEL_RST 2'h3
`define SACC_CHSEL_RST 4'hf
`define SACC_CHSEL_FIXED_REF 4'hf
// ****************************************************************
// timing
// ****************************************************************
`define SACC_DIV_SYS16 8'h10
`define SACC_DIV_SYS8 8'h08
`define SACC_DIV_SYS4 8'h04
`define SACC_DIV_OSC4 8'h04
`define SACC_CONV_PERIODS 4'hd
`define SACC_SAMPLE_PERIODS 4'h3
`define SACC_SHIFTS 4'h9
`endif

// ### core/sacc_bit_timer.v
// conversion bit period generator: divides a clock enable source by the latched divisor
`timescale 1ns/10ps
module sacc_bit_timer (
   input wire clock_i,
   input wire rst_n_i,
   input wire run_i,
   input wire src_tick_i,
   input wire [7:0] divisor_i,
   output reg period_tick_o
);
   reg [7:0] count;
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= 8'h00;
         period_tick_o <= 1'b0;
      end else if (!run_i) begin
         count <= 8'h00;
         period_tick_o <= 1'b0;
      end else if (src_tick_i) begin
         if (count == divisor_i - 8'h01) begin
            count <= 8'h00;
            period_tick_o <= 1'b1;
         end else begin
            count <= count + 8'h01;
            period_tick_o <= 1'b0;
         end
      end else begin
         period_tick_o <= 1'b0;
      end
   end
endmodule

// ### core/sacc_conv_ctrl.v
// successive-approximation converter control and sequencing with its register port
`timescale 1ns/10ps
`include "sacc_defines.vh"
module sacc_conv_ctrl (
   input wire clock_i,
   input wire rst_n_i,
   input wire [1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire sys_tick_i,
   input wire osc_i,
   input wire sleep_i,
   input wire compare_i,
   output reg [7:0] dac_code_o,
   output reg [3:0] channel_o,
   output reg converter_on_o,
   output reg sample_o,
   output reg conversion_done_flag_o
);
   // ****************************************************************
   // state
   // ****************************************************************
   localparam ST_IDLE = 3'b001;
   localparam ST_SAMPLE = 3'b010;
   localparam ST_RESOLVE = 3'b100;
   reg [2:0] state;
   reg [1:0] conv_clock_select;
   reg [3:0] input_channel_select;
   reg go;
   reg converter_on;
   reg [7:0] conversion_result;
   reg [8:0] shifter;
   reg [7:0] divisor;
   reg use_osc;
   reg [3:0] period_count;
   reg [3:0] shift_count;
   reg osc_s1;
   reg osc_s2;
   reg osc_s3;
   reg osc_prev;
   reg sleep_prev;
   wire osc_tick;
   wire src_tick;
   wire bit_tick;
   wire sleep_entry;
   wire wr_ctrl;
   wire running;
   wire abort_req;
   wire finish_tick;
   wire start_req;
   wire [7:0] next_result;
   wire [8:0] next_shifter;
   reg [7:0] next_divisor;
   reg next_use_osc;
   assign wr_ctrl = wr_i && (addr_i == `SACC_OFS_CONTROL);
   assign running = (state != ST_IDLE);
   assign sleep_entry = sleep_i && !sleep_prev;
   // oscillator is from another domain: three stages, edge counts when stages two and three agree
   assign osc_tick = osc_s2 && osc_s3 && !osc_prev;
   assign src_tick = use_osc ? osc_tick : sys_tick_i;
   // any control write that drops go or converter-on stops the running conversion
   assign abort_req = wr_ctrl && (!wdata_i[`SACC_GO_BIT] || !wdata_i[`SACC_ON_BIT]);
   // sleep entry outranks a finish in the same cycle, so no done flag is raised then
   assign finish_tick = (state == ST_RESOLVE) && !sleep_entry && !abort_req && bit_tick &&
      (period_count == `SACC_CONV_PERIODS - 4'h1);
   assign start_req = (state == ST_IDLE) && !sleep_entry && wr_ctrl && wdata_i[`SACC_GO_BIT] &&
      wdata_i[`SACC_ON_BIT] && converter_on;
   // ****************************************************************
   // input synchronising
   // ****************************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_s1 <= osc_i;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
         if (osc_s2 == osc_s3) begin
            osc_prev <= osc_s3;
         end
      end
   end
   // sleep comes from the core clock domain, so a plain edge register is enough
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sleep_prev <= 1'b0;
      end else begin
         sleep_prev <= sleep_i;
      end
   end
   sacc_bit_timer u_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .run_i(running),
      .src_tick_i(src_tick),
      .divisor_i(divisor),
      .period_tick_o(bit_tick)
   );
   // ****************************************************************
   // clock select decode
   // ****************************************************************
   // decoded from the starting write itself, so a select written later waits for the next start
   always @* begin
      next_use_osc = 1'b0;
      case (wdata_i[`SACC_CLKSEL_HI:`SACC_CLKSEL_LO])
         2'h0: next_divisor = `SACC_DIV_SYS16;
         2'h1: next_divisor = `SACC_DIV_SYS8;
         2'h2: next_divisor = `SACC_DIV_SYS4;
         default: begin
            next_divisor = `SACC_DIV_OSC4;
            next_use_osc = 1'b1;
         end
      endcase
   end
   // ****************************************************************
   // bit resolution step
   // ****************************************************************
   // shifter[8:1] is where the marker lands, shifter[7:0] the bit now being decided
   assign next_shifter = {1'b0, shifter[8:1]};
   genvar bit_idx;
   generate
      for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_resolve
         // decided bit takes the comparator, the next bit down takes the marker
         assign next_result[bit_idx] = shifter[bit_idx] ? compare_i :
            (shifter[bit_idx + 1] ? 1'b1 : conversion_result[bit_idx]);
      end
   endgenerate
   // ****************************************************************
   // conversion-done flag
   // ****************************************************************
   // the set wins over a software clear in the same cycle, so a finish is never lost
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conversion_done_flag_o <= 1'b0;
      end else if (finish_tick) begin
         conversion_done_flag_o <= 1'b1;
      end else if (wr_i && (addr_i == `SACC_OFS_DONE) && !wdata_i[0]) begin
         conversion_done_flag_o <= 1'b0;
      end
   end
   // ****************************************************************
   // active channel
   // ****************************************************************
   // the channel follows the select only between conversions, so a running result stays valid
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         channel_o <= `SACC_CHSEL_RST;
      end else if (start_req) begin
         channel_o <= wdata_i[`SACC_CHSEL_HI:`SACC_CHSEL_LO];
      end else if (!running) begin
         channel_o <= input_channel_select;
      end
   end
   // ****************************************************************
   // control register and sequencer
   // ****************************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_clock_select <= `SACC_CLKSEL_RST;
         input_channel_select <= `SACC_CHSEL_RST;
         go <= 1'b0;
         converter_on <= 1'b0;
         conversion_result <= 8'h00;
         shifter <= 9'h000;
         state <= ST_IDLE;
         divisor <= `SACC_DIV_OSC4;
         use_osc <= 1'b1;
         period_count <= 4'h0;
         shift_count <= 4'h0;
      end else if (sleep_entry) begin
         // partial result stays where it is
         go <= 1'b0;
         converter_on <= 1'b0;
         state <= ST_IDLE;
         conv_clock_select <= `SACC_CLKSEL_RST;
         input_channel_select <= `SACC_CHSEL_RST;
      end else begin
         if (wr_ctrl) begin
            conv_clock_select <= wdata_i[`SACC_CLKSEL_HI:`SACC_CLKSEL_LO];
            input_channel_select <= wdata_i[`SACC_CHSEL_HI:`SACC_CHSEL_LO];
            converter_on <= wdata_i[`SACC_ON_BIT];
         end
         if (wr_i && addr_i == `SACC_OFS_RESULT) begin
            conversion_result <= wdata_i;
         end
         case (state)
            ST_IDLE: begin
               // a go written while the converter is off falls through here and is lost
               if (start_req) begin
                  go <= 1'b1;
                  state <= ST_SAMPLE;
                  period_count <= 4'h0;
                  shift_count <= 4'h0;
                  // divisor latched here so later selects wait for the next start
                  use_osc <= next_use_osc;
                  divisor <= next_divisor;
               end
            end
            ST_SAMPLE: begin
               // old result left untouched while sampling
               if (wr_ctrl && !wdata_i[`SACC_GO_BIT]) begin
                  go <= 1'b0;
                  state <= ST_IDLE;
               end else if (wr_ctrl && !wdata_i[`SACC_ON_BIT]) begin
                  go <= 1'b0;
                  state <= ST_IDLE;
               end else if (bit_tick) begin
                  period_count <= period_count + 4'h1;
                  if (period_count == `SACC_SAMPLE_PERIODS - 4'h1) begin
                     conversion_result <= 8'h00;
                     shifter <= 9'h100;
                     state <= ST_RESOLVE;
                  end
               end
            end
            ST_RESOLVE: begin
               if (wr_ctrl && !wdata_i[`SACC_GO_BIT]) begin
                  go <= 1'b0;
                  state <= ST_IDLE;
               end else if (wr_ctrl && !wdata_i[`SACC_ON_BIT]) begin
                  go <= 1'b0;
                  state <= ST_IDLE;
               end else if (bit_tick) begin
                  period_count <= period_count + 4'h1;
                  // nine shifts: one brings the marker in, eight decide the bits behind it
                  if (shift_count < `SACC_SHIFTS) begin
                     shifter <= next_shifter;
                     conversion_result <= next_result;
                     shift_count <= shift_count + 4'h1;
                  end
                  if (finish_tick) begin
                     go <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // ****************************************************************
   // analog side outputs
   // ****************************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dac_code_o <= 8'h00;
         converter_on_o <= 1'b0;
         sample_o <= 1'b0;
      end else begin
         dac_code_o <= conversion_result;
         converter_on_o <= converter_on;
         sample_o <= (state == ST_SAMPLE);
      end
   end
   // ****************************************************************
   // read port
   // ****************************************************************
   // read data drop to zero outside the answer cycle so a stray sample never shows stale data
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         if (rd_i) begin
            case (addr_i)
               `SACC_OFS_CONTROL: rdata_o <= {conv_clock_select, input_channel_select, go, converter_on};
               `SACC_OFS_RESULT: rdata_o <= conversion_result;
               `SACC_OFS_DONE: rdata_o <= {7'h00, conversion_done_flag_o};
               default: rdata_o <= 8'h00;
            endcase
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end
endmodule

// ### bench/sacc_conv_ctrl_assertions.sv
// port checks for the conversion control block
`timescale 1ns/10ps
module sacc_conv_ctrl_assertions (
   input wire clock_i,
   input wire rst_n_i,
   input wire [1:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire sleep_i,
   input wire [7:0] dac_code_o,
   input wire [3:0] channel_o,
   input wire converter_on_o,
   input wire sample_o,
   input wire conversion_done_flag_o
);
   // ****
   // helper: cycles since sampling ended, saturating
   // ****
   logic [5:0] since_sample;
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) since_sample <= 6'h0;
      else if (sample_o) since_sample <= 6'h0;
      else if (since_sample != 6'h3f) since_sample <= since_sample + 6'h1;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_sample_start;
      $rose(sample_o);
   endsequence
   // ****
   // assertions
   // ****
   chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not idle");
   chk_on_set: assert property (wr_i && addr_i == 2'h0 && wdata_i[0] && !sleep_i |-> ##[1:2] converter_on_o)
      else $error("converter did not power up");
   chk_on_clear: assert property (wr_i && addr_i == 2'h0 && !wdata_i[0] |-> ##[1:2] !converter_on_o)
      else $error("converter did not shut down");
   chk_sleep_off: assert property ($rose(sleep_i) |-> ##[1:4] !converter_on_o) else $error("sleep left power on");
   chk_sample_on: assert property (sample_o |-> converter_on_o) else $error("sampling while off");
   chk_sample_len: assert property (s_sample_start |-> sample_o [*4]) else $error("sampling too short");
   chk_result_hold: assert property (sample_o && $past(sample_o) |-> $stable(dac_code_o))
      else $error("result changed while sampling");
   chk_channel_hold: assert property (sample_o && $past(sample_o) |-> $stable(channel_o))
      else $error("channel changed mid conversion");
   chk_done_late: assert property ($rose(conversion_done_flag_o) |-> since_sample >= 6'h20)
      else $error("done flag too early");
   chk_result_clear: assert property ($fell(sample_o) |-> dac_code_o == 8'h00)
      else $error("result not cleared after sampling");
endmodule
bind sacc_conv_ctrl sacc_conv_ctrl_assertions u_chk (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .sleep_i, .dac_code_o, .channel_o, .converter_on_o, .sample_o, .conversion_done_flag_o);

// ### bench/tb_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/10ps
`define CHK(g,e) begin n_tests++; if ((g)!==(e)) begin bad_count++; $display("MISMATCH t=%0t got=%h exp=%h",$time,g,e); end end
module tb_top;
   logic clock_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, sys_tick_i = 0, osc_i = 0, sleep_i = 0, compare_i = 0;
   logic [1:0] addr_i = 0;
   logic [7:0] wdata_i = 0, rdata_o, dac_code_o, rd_val, mid, vin = 0, prev = 8'h5a;
   logic [3:0] channel_o;
   logic converter_on_o, sample_o, conversion_done_flag_o;
   logic [31:0] seed = 32'd51;
   logic [3:0] tick_cnt = 0;
   int bad_count = 0, n_tests = 0, ctl, t0, n, el, d, p;
   int div_q[$] = '{16, 8, 4};
   logic [3:0] ch_tab[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf, 4'h2};
   sacc_conv_ctrl u_sacc_conv_ctrl (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sys_tick_i, .osc_i,
      .sleep_i, .compare_i, .dac_code_o, .channel_o, .converter_on_o, .sample_o, .conversion_done_flag_o);
   initial forever #4 clock_i = ~clock_i;
   // oscillator toggles every 72 ns, always on a falling edge of the system clock
   initial forever #72 osc_i = ~osc_i;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   always @(posedge clock_i) begin
      seed <= xs(seed);
      compare_i <= (vin >= dac_code_o);
      tick_cnt <= tick_cnt + 4'h1;
      sys_tick_i <= (tick_cnt == 4'hf);
   end
   // ****
   // bus tasks
   // ****
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
   endtask
   // resolved bits above the marker must match the held input
   task automatic chk_partial();
      rd(2'h1);
      p = 0;
      while (p < 8 && rd_val[p] !== 1'b1) p++;
      `CHK(p > 0 && p < 8, 1'b1)
      `CHK(rd_val >> (p + 1), vin >> (p + 1))
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 rd_val = rdata_o;
   endtask
   // polling is bounded so a stuck go flag ends the run
   task automatic wait_idle();
      n = 0;
      do begin
         rd(2'h0);
         n++;
      end while (rd_val[1] === 1'b1 && n < 4000);
      if (n >= 4000) begin
         bad_count++;
         conclude();
      end
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(2'h0); `CHK(rd_val, 8'hfc)
      `CHK(channel_o, 4'hf)
      rd(2'h3); `CHK(rd_val, 8'h00)
      wr(2'h1, 8'h5a); rd(2'h1); `CHK(rd_val, 8'h5a)
      wr(2'h0, 8'h02); rd(2'h0); `CHK(rd_val, 8'h00)
      for (int i = 0; i < 10; i++) begin
         ctl = ((i % 4) << 6) | (ch_tab[i] << 2) | 1;
         mid = 8'((((3 - i % 4) << 6) | ((ch_tab[i] ^ 4'h1) << 2)) | 3);
         vin = seed[7:0];
         wr(2'h2, 8'h00);
         wr(2'h0, 8'(ctl));
         t0 = $time;
         wr(2'h0, 8'(ctl | 2));
         wr(2'h0, mid); `CHK(channel_o, ch_tab[i])
         rd(2'h1); `CHK(rd_val, prev)
         wait_idle();
         el = ($time - t0) / 8;
         if (i % 4 < 3) begin
            d = div_q[i % 4] * 16;
            `CHK(el >= 12 * d && el <= 15 * d + 6, 1'b1)
         end
         rd(2'h2); `CHK(rd_val[0], 1'b1)
         rd(2'h0); `CHK(rd_val, mid & 8'hfd)
         rd(2'h1); `CHK(rd_val, vin)
         prev = vin;
      end
      // abort in mid conversion keeps the partial result
      vin = seed[7:0];
      wr(2'h2, 8'h00); wr(2'h0, 8'h81); wr(2'h0, 8'h83);
      repeat (500) @(posedge clock_i);
      wr(2'h0, 8'h81);
      repeat (60) @(posedge clock_i);
      rd(2'h0); `CHK(rd_val, 8'h81)
      rd(2'h2); `CHK(rd_val[0], 1'b0)
      chk_partial();
      // sleep entry during a conversion
      vin = seed[7:0];
      wr(2'h0, 8'h43); wr(2'h0, 8'h83);
      repeat (700) @(posedge clock_i);
      sleep_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      rd(2'h0); `CHK(rd_val, 8'hfc)
      `CHK(converter_on_o, 1'b0)
      rd(2'h2); `CHK(rd_val[0], 1'b0)
      chk_partial();
      sleep_i <= 1'b0;
      conclude();
   end
endmodule
